// >>> hw/mcrb_pkg.sv
// Purpose: Constants for the modem control register bank.
// Assumes: Single 100 MHz clock, synchronous active-high reset.
// Notes:   Offsets are 3-bit register addresses, fields are bit positions.
// How it works
// - Five 8-bit registers serve the host for control and status monitoring.
// - The host picks a register with three serial address pins or the low three muxed bus lines.
// - In parallel mode the address is caught from the muxed bus by the latch strobe.
// - All registers are read and written except line detect status and identity, which ignore writes.
// - Addresses 0, 1, 2, 3 and 6 decode to mode, interface, detect, tone and identity.
// - Addresses 4 and 5 are reserved locations with no function here.
// - Mode control holds transmit mode in bits 5..2, transmit enable in 1, originate in 0.
// - Originate set sends low band and hears high band; clear does the opposite.
// - Transmit enable gates the analog transmit output.
// - Answer tone and tone dialling reach the line only while transmit is enabled.
// - Interface control holds pattern, interrupt enable, bypass, clock, reset and test mode.
// - Line detect status reports rx data, marks, carrier, answer tone, progress, long loop.
// - Tone control holds rx data gate, answer tone, tone dial enable and the digit code.
package mcrb_pkg;

  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 3;

  localparam logic [2:0]  ADDR_LINE_MODE  = 3'h0;
  localparam logic [2:0]  ADDR_HOST_IF    = 3'h1;
  localparam logic [2:0]  ADDR_DETECT     = 3'h2;
  localparam logic [2:0]  ADDR_TONE       = 3'h3;
  localparam logic [2:0]  ADDR_RSVD_A     = 3'h4;
  localparam logic [2:0]  ADDR_RSVD_B     = 3'h5;
  localparam logic [2:0]  ADDR_IDENTITY   = 3'h6;

  // Mode control fields
  localparam int          LM_ORIG_BIT     = 0;
  localparam int          LM_TXEN_BIT     = 1;
  localparam int          LM_MODE_LSB     = 2;
  localparam int          LM_MODE_W       = 4;
  localparam logic [7:0]  LM_MASK         = 8'h3f;
  localparam logic [3:0]  LM_MODE_PWRDN   = 4'h0;

  // Interface control fields
  localparam int          HI_TEST_LSB     = 0;
  localparam int          HI_RESET_BIT    = 2;
  localparam int          HI_CLK_BIT      = 3;
  localparam int          HI_BYPASS_BIT   = 4;
  localparam int          HI_DETINT_BIT   = 5;
  localparam int          HI_PATT_LSB     = 6;
  localparam logic [7:0]  HI_MASK         = 8'hff;

  // Detect status fields, six live bits
  localparam int          DET_W           = 6;
  localparam logic [7:0]  DET_MASK        = 8'h3f;

  // Tone control fields
  localparam int          TC_DIGIT_LSB    = 0;
  localparam int          TC_DTMF_BIT     = 4;
  localparam int          TC_ANS_BIT      = 5;
  localparam int          TC_RXGATE_BIT   = 7;
  localparam logic [7:0]  TC_MASK         = 8'hbf;

  // Identity code sits in the upper nibble
  localparam int          ID_LSB          = 4;

  localparam logic [7:0]  RESET_VAL       = 8'h00;

endpackage : mcrb_pkg

// >>> hw/mcrb_top.sv
// Purpose: Host-facing register bank of a single-chip modem, serial or muxed parallel port.
// Assumes: All pins are synchronous to mclk_in; active-low strobes are sampled each cycle.
// Notes:   Control fields leave as registered outputs; ce_in low freezes every flip-flop unless rst_in is high.
`timescale 1ns/1ns
`default_nettype none
module mcrb_top #(
  parameter logic [3:0] PART_ID = 4'h5  // Arbitrary identification value
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire logic             serial_mode_in,
  // Serial control port
  input  wire logic             serial_reg_addr_0_in,
  input  wire logic             serial_reg_addr_1_in,
  input  wire logic             serial_reg_addr_2_in,
  input  wire logic             exclk_in,
  input  wire logic             serial_data_in,
  output logic                  serial_data_out,
  output logic                  serial_data_oe_out,
  // Muxed parallel control port
  input  wire logic [7:0]       muxed_bus_in,
  output logic      [7:0]       muxed_bus_out,
  output logic                  muxed_bus_oe_out,
  input  wire logic             addr_latch_in,
  input  wire logic             chip_sel_n_in,
  // Shared strobes
  input  wire logic             read_n_in,
  input  wire logic             write_n_in,
  // Monitored line conditions
  input  wire logic [5:0]       line_detect_in,
  // Control fields towards the modem core
  output logic                  originate_out,
  output logic                  tx_enable_out,
  output logic      [3:0]       tx_mode_out,
  output logic                  power_down_out,
  output logic                  analog_transmit_out,
  output logic                  answer_tone_tx_out,
  output logic                  dtmf_tx_out,
  output logic      [3:0]       dtmf_digit_out,
  output logic                  rx_data_gate_out,
  output logic      [1:0]       tx_pattern_out,
  output logic                  detect_int_en_out,
  output logic                  bypass_scrambler_out,
  output logic                  clk_control_out,
  output logic                  soft_reset_out,
  output logic      [1:0]       test_mode_out
);

  if (mcrb_pkg::DATA_W != 8 || mcrb_pkg::ADDR_W != 3) begin : g_width_check
    $error("Register bank is built for 8-bit data and 3-bit addresses");
  end

  typedef enum logic [2:0] {
    ACC_IDLE  = 3'b001,
    ACC_READ  = 3'b010,
    ACC_WRITE = 3'b100
  } mcrb_acc_e;

  mcrb_acc_e    acc_reg;
  mcrb_acc_e    acc_next;

  logic [7:0]   line_mode_control_reg;
  logic [7:0]   host_interface_control_reg;
  logic [7:0]   line_detect_status_reg;
  logic [7:0]   tone_control_reg;

  logic         exclk_prev_reg;
  logic         read_n_prev_reg;
  logic         write_n_prev_reg;
  logic         ale_prev_reg;
  logic [2:0]   par_addr_reg;
  logic [7:0]   par_wdata_reg;
  logic [7:0]   ser_shift_in_reg;
  logic [7:0]   ser_shift_out_reg;
  logic [2:0]   ser_bit_cnt_reg;

  logic [2:0]   ser_addr;
  logic [2:0]   acc_addr;
  logic         exclk_fall;
  logic         read_fall;
  logic         write_rise;
  logic         ale_fall;
  logic         par_sel;
  logic         wr_commit;
  logic [7:0]   wr_data;
  logic [7:0]   rd_data;
  logic [3:0]   mode_field;
  logic         pwr_down;
  logic         tx_live;

  assign ser_addr   = {serial_reg_addr_2_in, serial_reg_addr_1_in, serial_reg_addr_0_in};
  assign exclk_fall = exclk_prev_reg & ~exclk_in;
  assign read_fall  = read_n_prev_reg & ~read_n_in;
  assign write_rise = ~write_n_prev_reg & write_n_in;
  assign ale_fall   = ale_prev_reg & ~addr_latch_in;
  assign par_sel    = ~serial_mode_in & ~chip_sel_n_in;

  assign acc_addr   = serial_mode_in ? ser_addr : par_addr_reg;
  assign wr_data    = serial_mode_in ? ser_shift_in_reg : par_wdata_reg;
  assign wr_commit  = write_rise & (acc_reg == ACC_WRITE);

  // Strobe edge history
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      exclk_prev_reg   <= 1'b1;
      read_n_prev_reg  <= 1'b1;
      write_n_prev_reg <= 1'b1;
      ale_prev_reg     <= 1'b0;
    end else if (ce_in) begin
      exclk_prev_reg   <= exclk_in;
      read_n_prev_reg  <= read_n_in;
      write_n_prev_reg <= write_n_in;
      ale_prev_reg     <= addr_latch_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      par_addr_reg <= 3'h0;
    end else if (ce_in && !serial_mode_in && ale_fall) begin
      par_addr_reg <= muxed_bus_in[2:0];
    end
  end

  // Access phase tracking
  always_comb begin
    acc_next = acc_reg;
    unique case (acc_reg)
      ACC_IDLE: begin
        if ((serial_mode_in || par_sel) && !read_n_in) begin
          acc_next = ACC_READ;
        end else if ((serial_mode_in || par_sel) && !write_n_in) begin
          acc_next = ACC_WRITE;
        end
      end
      ACC_READ: begin
        if (read_n_in) begin
          acc_next = ACC_IDLE;
        end
      end
      ACC_WRITE: begin
        if (write_n_in) begin
          acc_next = ACC_IDLE;
        end
      end
      default: acc_next = ACC_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      acc_reg <= ACC_IDLE;
    end else if (ce_in) begin
      acc_reg <= acc_next;
    end
  end

  // Parallel write data follows the bus while the write strobe is low
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      par_wdata_reg <= 8'h00;
    end else if (ce_in && par_sel && !write_n_in) begin
      par_wdata_reg <= muxed_bus_in;
    end
  end

  // Serial write shifter, LSB first on falling clock edges
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ser_shift_in_reg <= 8'h00;
    end else if (ce_in && serial_mode_in && read_n_in && exclk_fall) begin
      ser_shift_in_reg <= {serial_data_in, ser_shift_in_reg[7:1]};
    end
  end

  always_comb begin
    unique case (acc_addr)
      mcrb_pkg::ADDR_LINE_MODE: rd_data = line_mode_control_reg;
      mcrb_pkg::ADDR_HOST_IF:   rd_data = host_interface_control_reg;
      mcrb_pkg::ADDR_DETECT:    rd_data = line_detect_status_reg;
      mcrb_pkg::ADDR_TONE:      rd_data = tone_control_reg;
      mcrb_pkg::ADDR_IDENTITY:  rd_data = {PART_ID, 4'h0};
      default:                  rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      line_mode_control_reg <= mcrb_pkg::RESET_VAL;
    end else if (ce_in && wr_commit && acc_addr == mcrb_pkg::ADDR_LINE_MODE) begin
      line_mode_control_reg <= wr_data & mcrb_pkg::LM_MASK;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      host_interface_control_reg <= mcrb_pkg::RESET_VAL;
    end else if (ce_in && wr_commit && acc_addr == mcrb_pkg::ADDR_HOST_IF) begin
      host_interface_control_reg <= wr_data & mcrb_pkg::HI_MASK;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tone_control_reg <= mcrb_pkg::RESET_VAL;
    end else if (ce_in && wr_commit && acc_addr == mcrb_pkg::ADDR_TONE) begin
      tone_control_reg <= wr_data & mcrb_pkg::TC_MASK;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      line_detect_status_reg <= mcrb_pkg::RESET_VAL;
    end else if (ce_in) begin
      line_detect_status_reg <= {2'b00, line_detect_in} & mcrb_pkg::DET_MASK;
    end
  end

  // Serial read: load on read fall, then one bit per falling clock
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ser_shift_out_reg <= 8'h00;
      ser_bit_cnt_reg   <= 3'h0;
      serial_data_out   <= 1'b0;
    end else if (ce_in && serial_mode_in) begin
      if (read_fall) begin
        ser_shift_out_reg <= {1'b0, rd_data[7:1]};
        ser_bit_cnt_reg   <= 3'h0;
        serial_data_out   <= rd_data[0];
      end else if (!read_n_in && exclk_fall && ser_bit_cnt_reg != 3'h7) begin
        ser_shift_out_reg <= {1'b0, ser_shift_out_reg[7:1]};
        ser_bit_cnt_reg   <= ser_bit_cnt_reg + 3'h1;
        serial_data_out   <= ser_shift_out_reg[0];
      end
    end
  end

  // Data leaves only while the read strobe is low
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      serial_data_oe_out <= 1'b0;
    end else if (ce_in) begin
      serial_data_oe_out <= serial_mode_in & ~read_n_in;
    end
  end

  // Parallel read drives the bus while selected, read is low and the address latch strobe is low
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      muxed_bus_out    <= 8'h00;
      muxed_bus_oe_out <= 1'b0;
    end else if (ce_in) begin
      muxed_bus_out    <= rd_data;
      muxed_bus_oe_out <= par_sel & ~read_n_in & ~addr_latch_in;
    end
  end

  assign mode_field = line_mode_control_reg[mcrb_pkg::LM_MODE_LSB +: mcrb_pkg::LM_MODE_W];
  assign pwr_down   = (mode_field == mcrb_pkg::LM_MODE_PWRDN);
  assign tx_live    = line_mode_control_reg[mcrb_pkg::LM_TXEN_BIT] & ~pwr_down;

  // Mode control fields towards the modem core
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      originate_out       <= 1'b0;
      tx_enable_out       <= 1'b0;
      tx_mode_out         <= 4'h0;
      power_down_out      <= 1'b1;
      analog_transmit_out <= 1'b0;
    end else if (ce_in) begin
      originate_out       <= line_mode_control_reg[mcrb_pkg::LM_ORIG_BIT];
      tx_enable_out       <= line_mode_control_reg[mcrb_pkg::LM_TXEN_BIT];
      tx_mode_out         <= mode_field;
      power_down_out      <= pwr_down;
      analog_transmit_out <= tx_live;
    end
  end

  // Tone sources towards the transmitter, plus the rx data gate
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      answer_tone_tx_out <= 1'b0;
      dtmf_tx_out        <= 1'b0;
      dtmf_digit_out     <= 4'h0;
      rx_data_gate_out   <= 1'b0;
    end else if (ce_in) begin
      answer_tone_tx_out <= tone_control_reg[mcrb_pkg::TC_ANS_BIT] & tx_live;
      dtmf_tx_out        <= tone_control_reg[mcrb_pkg::TC_DTMF_BIT] & tx_live;
      dtmf_digit_out     <= tone_control_reg[mcrb_pkg::TC_DIGIT_LSB +: 4];
      rx_data_gate_out   <= tone_control_reg[mcrb_pkg::TC_RXGATE_BIT];
    end
  end

  // Interface control fields
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tx_pattern_out       <= 2'h0;
      detect_int_en_out    <= 1'b0;
      bypass_scrambler_out <= 1'b0;
      clk_control_out      <= 1'b0;
      soft_reset_out       <= 1'b0;
      test_mode_out        <= 2'h0;
    end else if (ce_in) begin
      tx_pattern_out       <= host_interface_control_reg[mcrb_pkg::HI_PATT_LSB +: 2];
      detect_int_en_out    <= host_interface_control_reg[mcrb_pkg::HI_DETINT_BIT];
      bypass_scrambler_out <= host_interface_control_reg[mcrb_pkg::HI_BYPASS_BIT];
      clk_control_out      <= host_interface_control_reg[mcrb_pkg::HI_CLK_BIT];
      soft_reset_out       <= host_interface_control_reg[mcrb_pkg::HI_RESET_BIT];
      test_mode_out        <= host_interface_control_reg[mcrb_pkg::HI_TEST_LSB +: 2];
    end
  end

endmodule : mcrb_top
`default_nettype wire

// >>> tb/mcrb_properties.sv
// Purpose: Port-level properties of the register bank.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to mcrb_top after the module.
`timescale 1ns/1ns
`default_nettype none
module mcrb_properties (
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic       ce_in,
  input wire logic       serial_mode_in,
  input wire logic       addr_latch_in,
  input wire logic       chip_sel_n_in,
  input wire logic       read_n_in,
  input wire logic       write_n_in,
  input wire logic       muxed_bus_oe_out,
  input wire logic       originate_out,
  input wire logic       tx_enable_out,
  input wire logic [3:0] tx_mode_out,
  input wire logic       power_down_out,
  input wire logic       analog_transmit_out,
  input wire logic       answer_tone_tx_out,
  input wire logic       dtmf_tx_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_rd_req;
    !serial_mode_in && ce_in && !chip_sel_n_in && !read_n_in && !addr_latch_in;
  endsequence
  sequence s_no_wr;
    write_n_in [*3];
  endsequence
  property p_pwr_dn; power_down_out == (tx_mode_out == 4'h0); endproperty
  a_pwr_dn: assert property (p_pwr_dn) else $error("power down disagrees with mode");
  property p_tx_gate; analog_transmit_out == (tx_enable_out && !power_down_out); endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("transmit output gating wrong");
  property p_ans_gate; answer_tone_tx_out |-> analog_transmit_out; endproperty
  a_ans_gate: assert property (p_ans_gate) else $error("answer tone without transmit");
  property p_dtmf_gate; dtmf_tx_out |-> tx_enable_out && !power_down_out; endproperty
  a_dtmf_gate: assert property (p_dtmf_gate) else $error("dial tone without transmit");
  property p_rd_oe; s_rd_req |=> muxed_bus_oe_out; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("read not answered");
  property p_oe_cause;
    muxed_bus_oe_out |-> $past(read_n_in) == 1'b0 && $past(chip_sel_n_in) == 1'b0;
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
  property p_hold;
    s_no_wr |=> $stable({tx_mode_out, tx_enable_out, originate_out});
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed without write");
  property p_reset;
    disable iff (1'b0) rst_in && ce_in |=> power_down_out && !analog_transmit_out && !dtmf_tx_out;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : mcrb_properties
bind mcrb_top mcrb_properties u_mcrb_properties (.mclk_in, .rst_in, .ce_in, .serial_mode_in,
  .addr_latch_in, .chip_sel_n_in, .read_n_in, .write_n_in, .muxed_bus_oe_out, .originate_out,
  .tx_enable_out, .tx_mode_out, .power_down_out, .analog_transmit_out, .answer_tone_tx_out,
  .dtmf_tx_out);
`default_nettype wire

// >>> tb/mcrb_host_model.sv
// Purpose: Host processor on the muxed parallel control port.
// Assumes: Drives on falling edges; design samples on rising.
// Notes:   Released bus shows the inverse of its last value.
`timescale 1ns/1ns
`default_nettype none
module mcrb_host_model (
  input wire logic  clk_in,
  output logic [7:0] bus_out,
  output logic       ale_out,
  output logic       cs_n_out,
  output logic       rd_n_out,
  output logic       wr_n_out
);
  initial begin
    {ale_out, cs_n_out, rd_n_out, wr_n_out} = 4'hf;
    ale_out = 1'b0;
    bus_out = 8'h00;
  end
  task automatic put_addr(input logic [2:0] a);
    @(negedge clk_in) ale_out = 1'b1;
    bus_out = {5'h00, a};
    @(negedge clk_in) ale_out = 1'b0;
  endtask : put_addr
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = a == 3'h0 ? mcrb_pkg::LM_MASK : a == 3'h3 ? mcrb_pkg::TC_MASK : 8'hff;
    put_addr(a);
    @(negedge clk_in) cs_n_out = 1'b0;
    wr_n_out = 1'b0;
    bus_out = d & m;
    @(negedge clk_in) wr_n_out = 1'b1;
    @(negedge clk_in) cs_n_out = 1'b1;
    bus_out = ~bus_out;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    put_addr(a);
    @(negedge clk_in) cs_n_out = 1'b0;
    rd_n_out = 1'b0;
    bus_out = ~bus_out;
    @(negedge clk_in) bus_out = ~bus_out;
    @(negedge clk_in) rd_n_out = 1'b1;
    cs_n_out = 1'b1;
  endtask : rd
endmodule : mcrb_host_model
`default_nettype wire

// >>> tb/mcrb_tb_top.sv
// Purpose: Self-checking bench for the register bank.
// Assumes: Parallel port first, serial pins carry noise; a serial pass closes the run.
// Notes:   Parallel reads are scored from a queue by a monitor.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module mcrb_tb_top;
  localparam logic [3:0] PART_CODE = 4'h9;  // Arbitrary identification value
  logic       mclk_in, rst_in, ce_in, serial_mode_in, exclk_in, serial_data_in;
  logic       serial_reg_addr_0_in, serial_reg_addr_1_in, serial_reg_addr_2_in;
  logic       addr_latch_in, chip_sel_n_in, read_n_in, write_n_in, oe_q;
  logic [7:0] muxed_bus_in, muxed_bus_out, host_bus, d, got;
  logic [5:0] line_detect_in;
  logic       serial_data_out, serial_data_oe_out, muxed_bus_oe_out, originate_out;
  logic       tx_enable_out, power_down_out, analog_transmit_out, answer_tone_tx_out;
  logic       dtmf_tx_out, rx_data_gate_out, detect_int_en_out, bypass_scrambler_out;
  logic       clk_control_out, soft_reset_out, atx;
  logic [3:0] tx_mode_out, dtmf_digit_out;
  logic [1:0] tx_pattern_out, test_mode_out;
  logic [7:0] m [8];
  logic [7:0] exp_q [$];
  logic [7:0] tbl [3] = '{8'h06, 8'h02, 8'h05};
  logic [31:0] seed = 32'hacf7;
  logic [31:0] noise = 32'hacf7;
  int         fails = 0, samples_checked = 0, cycles = 0;
  assign muxed_bus_in = muxed_bus_oe_out ? muxed_bus_out : host_bus;
  mcrb_top #(.PART_ID(PART_CODE)) u_mcrb_top (.mclk_in, .rst_in, .ce_in, .serial_mode_in,
    .serial_reg_addr_0_in, .serial_reg_addr_1_in, .serial_reg_addr_2_in, .exclk_in,
    .serial_data_in, .serial_data_out, .serial_data_oe_out, .muxed_bus_in, .muxed_bus_out,
    .muxed_bus_oe_out, .addr_latch_in, .chip_sel_n_in, .read_n_in, .write_n_in,
    .line_detect_in, .originate_out, .tx_enable_out, .tx_mode_out, .power_down_out,
    .analog_transmit_out, .answer_tone_tx_out, .dtmf_tx_out, .dtmf_digit_out,
    .rx_data_gate_out, .tx_pattern_out, .detect_int_en_out, .bypass_scrambler_out,
    .clk_control_out, .soft_reset_out, .test_mode_out);
  mcrb_host_model u_mcrb_host_model (.clk_in(mclk_in), .bus_out(host_bus),
    .ale_out(addr_latch_in), .cs_n_out(chip_sel_n_in), .rd_n_out(read_n_in),
    .wr_n_out(write_n_in));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // Serial write: eight falling shift clocks, LSB first, then a write pulse
  task automatic ser_wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge mclk_in) {serial_reg_addr_2_in, serial_reg_addr_1_in, serial_reg_addr_0_in} = a;
    for (int i = 0; i < 8; i++) begin
      @(negedge mclk_in) serial_data_in = v[i];
      exclk_in = 1'b1;
      @(negedge mclk_in) exclk_in = 1'b0;
    end
    @(negedge mclk_in) u_mcrb_host_model.wr_n_out = 1'b0;
    @(negedge mclk_in) u_mcrb_host_model.wr_n_out = 1'b1;
  endtask : ser_wr
  // Serial read: bit 0 after the read fall, one more bit per falling shift clock
  task automatic ser_rd(input logic [2:0] a, input logic [7:0] e);
    @(negedge mclk_in) {serial_reg_addr_2_in, serial_reg_addr_1_in, serial_reg_addr_0_in} = a;
    u_mcrb_host_model.rd_n_out = 1'b0;
    @(negedge mclk_in) `CHK("ser_oe", 1'b1, serial_data_oe_out)
    for (int i = 0; i < 8; i++) begin
      if (i > 0) begin
        @(negedge mclk_in) exclk_in = 1'b1;
        @(negedge mclk_in) exclk_in = 1'b0;
        @(negedge mclk_in);
      end
      `CHK("ser_bit", e[i], serial_data_out)
    end
    u_mcrb_host_model.rd_n_out = 1'b1;
  endtask : ser_rd
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // Serial pins are unused in parallel mode and carry noise
  always @(negedge mclk_in) begin
    noise = xs(noise);
    if (!serial_mode_in) begin
      {serial_reg_addr_2_in, serial_reg_addr_1_in, serial_reg_addr_0_in} <= noise[2:0];
      {exclk_in, serial_data_in} <= noise[4:3];
    end
  end
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial oe_q = 1'b0;
  always @(negedge mclk_in) begin
    if (muxed_bus_oe_out === 1'b1 && oe_q !== 1'b1) begin
      got = exp_q.size() > 0 ? exp_q.pop_front() : ~muxed_bus_out;
      `CHK("read", got, muxed_bus_out)
    end
    oe_q = muxed_bus_oe_out;
  end
  initial begin
    {rst_in, ce_in, serial_mode_in, exclk_in, serial_data_in} = 5'h18;
    {serial_reg_addr_2_in, serial_reg_addr_1_in, serial_reg_addr_0_in} = 3'h0;
    line_detect_in = 6'h2a;
    foreach (m[i]) m[i] = 8'h00;
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in) rst_in = 1'b0;
    for (int r = 0; r < 6; r++) begin
      for (int a = 0; a < 8; a++) begin
        seed = xs(seed);
        d = (a == 0 && r < 3) ? tbl[r] : (a == 3 ? seed[7:0] | 8'h30 : seed[7:0]);
        u_mcrb_host_model.wr(a[2:0], d);
        if (a == 0) m[0] = d & 8'h3f;
        if (a == 1) m[1] = d;
        if (a == 3) m[3] = d & 8'hbf;
      end
      seed = xs(seed);
      line_detect_in = seed[13:8];
      for (int a = 0; a < 8; a++) begin
        exp_q.push_back(a == 2 ? {2'h0, line_detect_in} : a == 6 ? {PART_CODE, 4'h0} : m[a]);
        u_mcrb_host_model.rd(a[2:0]);
      end
      repeat (2) @(negedge mclk_in);
      atx = m[0][1] && m[0][5:2] != 4'h0;
      `CHK("mode", m[0][5:0], {tx_mode_out, tx_enable_out, originate_out})
      `CHK("pwr", m[0][5:2] == 4'h0, power_down_out)
      `CHK("atx", atx, analog_transmit_out)
      `CHK("tones", {m[3][5] & atx, m[3][4] & atx}, {answer_tone_tx_out, dtmf_tx_out})
      `CHK("tone", {m[3][7], m[3][3:0]}, {rx_data_gate_out, dtmf_digit_out})
      `CHK("ifc", m[1], {tx_pattern_out, detect_int_en_out, bypass_scrambler_out,
        clk_control_out, soft_reset_out, test_mode_out})
      if (r == 3) begin
        rst_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        rst_in = 1'b0;
        foreach (m[i]) m[i] = 8'h00;
        `CHK("rst", 2'h2, {power_down_out, tx_enable_out})
      end
    end
    // Serial port pass: tone word in, then tone, identity and detect back
    @(negedge mclk_in) serial_mode_in = 1'b1;
    @(negedge mclk_in) exclk_in = 1'b1;
    seed = xs(seed);
    d = seed[7:0] & mcrb_pkg::TC_MASK;
    ser_wr(3'h3, d);
    ser_rd(3'h3, d);
    ser_rd(3'h6, {PART_CODE, 4'h0});
    ser_rd(3'h2, {2'h0, line_detect_in});
    @(negedge mclk_in) `CHK("ser_tone", d[3:0], dtmf_digit_out)
    tally_and_finish;
  end
endmodule : mcrb_tb_top
`default_nettype wire
